// ---- verilog/tcc_map.svh ----
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Register byte offsets
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_MODE 8'h04
`define TCC_OFS_IRQEN 8'h08
`define TCC_OFS_STATUS 8'h0C
`define TCC_OFS_IOAB 8'h10
`define TCC_OFS_IOCD 8'h14
`define TCC_OFS_COUNT 8'h18
`define TCC_OFS_GRA 8'h1C

// Control fields
`define TCC_CKS_FLD 2:0
`define TCC_CKS_EXT 2
`define TCC_COUNTER_CLEAR_ON_MATCH_A_BIT 3
`define TCC_START_BIT 4

// Mode fields
`define TCC_BUFFER_ENABLE_A_BIT 0
`define TCC_BUFFER_ENABLE_B_BIT 1

// Status and enable fields
`define TCC_IMF_FLD 3:0
`define TCC_OVF_BIT 4

// I/O control fields
`define TCC_IO_LO_FLD 2:0
`define TCC_IO_HI_FLD 6:4
`define TCC_IO_RSVD 8'h88

// Reset values and counter maximum
`define TCC_COUNT_RST 16'h0000
`define TCC_GR_RST 16'hFFFF
`define TCC_COUNT_MAX 16'hFFFF
`define TCC_IO_RST 8'h00

`endif

// ---- verilog/tcc_pkg.sv ----
package tcc_pkg;

    typedef logic [3:0] tcc_chan_t;

    typedef enum logic [1:0] {
        TCC_ACT_NONE = 2'b00,
        TCC_ACT_LOW = 2'b01,
        TCC_ACT_HIGH = 2'b10,
        TCC_ACT_TOGGLE = 2'b11
    } tcc_act_t;

    typedef enum logic [1:0] {
        TCC_EDGE_RISE = 2'b00,
        TCC_EDGE_FALL = 2'b01,
        TCC_EDGE_BOTH = 2'b10,
        TCC_EDGE_BOTH_ALT = 2'b11
    } tcc_edge_t;

endpackage

// ---- verilog/tcc_timer.sv ----
// What this block does
// [R01] Channel C/D control bits 7, 3 read one
// [R02] D function bit 6 picks compare or capture
// [R03] D compare action: hold, low, high, toggle
// [R04] D capture edge: rise, fall, both
// [R05] C function bit 2 picks compare or capture
// [R06] C compare action: hold, low, high, toggle
// [R07] C capture edge: rise, fall, both
// [R08] 16-bit read/write counter, selectable clock source
// [R09] Clear counter on match A when enabled
// [R10] Wrap sets overflow flag, may interrupt
// [R11] Software uses whole 16-bit counter accesses
// [R12] Counter resets to zero
// [R13] Compare match sets channel flag
// [R14] Enabled compare match raises interrupt
// [R15] Capture stores count and sets flag
// [R16] Enabled capture raises interrupt
// [R17] C buffers A, D buffers B
// [R18] Buffered compare reloads A or B
// [R19] Software uses whole 16-bit register accesses
// [R20] General registers reset to all ones
// [R21] Buffered capture shifts old value down
// [R22] Match acts when counter leaves value
// [R23] Flag clears by zero write after read
// [R24] Pins synchronised, one edge one capture
`timescale 1ns/10ps
`include "tcc_map.svh"
module tcc_timer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Timer pins, index 0..3 is channel A..D
    input wire tcc_pkg::tcc_chan_t timer_pin_in,
    output tcc_pkg::tcc_chan_t timer_pin_out,
    output tcc_pkg::tcc_chan_t timer_pin_oe_n,
    // External count clock
    input wire logic ext_count_clk,
    // Interrupt request
    output logic irq
);
    import tcc_pkg::*;

    logic [15:0] cnt_ff;
    logic [15:0] gr_ff [4];
    logic [7:0] io_ab_ff;
    logic [7:0] io_cd_ff;
    logic [2:0] cks_ff;
    logic counter_clear_on_match_a_ff;
    logic start_ff;
    logic [1:0] buf_ff;
    logic overflow_irq_enable_ff;
    logic [3:0] imie_ff;
    logic ovf_ff;
    logic [3:0] imf_ff;
    logic ovf_seen_ff;
    logic [3:0] imf_seen_ff;
    logic [2:0] pre_ff;
    tcc_chan_t pin_s1_ff;
    tcc_chan_t pin_s2_ff;
    tcc_chan_t pin_s3_ff;
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_s3_ff;
    tcc_chan_t out_ff;
    tcc_chan_t oe_n_ff;
    logic irq_ff;
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    logic [2:0] ctl [4];
    logic [3:0] cap_mode;
    logic [3:0] active;
    logic [3:0] match;
    logic [3:0] cap;
    logic [3:0] rise;
    logic [3:0] fall;
    logic tick;
    logic ovf_evt;
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rdata;

    function automatic logic [2:0] div_mask(input logic [1:0] sel);
        return 3'((4'h1 << sel) - 4'h1);
    endfunction

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        case (tcc_edge_t'(sel))
            TCC_EDGE_RISE: return r;
            TCC_EDGE_FALL: return f;
            default: return r | f;
        endcase
    endfunction

    function automatic logic act_next(input logic [1:0] sel, input logic cur);
        case (tcc_act_t'(sel))
            TCC_ACT_LOW: return 1'b0;
            TCC_ACT_HIGH: return 1'b1;
            TCC_ACT_TOGGLE: return ~cur;
            default: return cur;
        endcase
    endfunction

    function automatic logic [7:0] gr_addr(input logic [1:0] idx);
        return `TCC_OFS_GRA + {4'h0, idx, 2'b00};
    endfunction

    // Channel fields
    assign ctl[0] = io_ab_ff[`TCC_IO_LO_FLD];
    assign ctl[1] = io_ab_ff[`TCC_IO_HI_FLD];
    assign ctl[2] = io_cd_ff[`TCC_IO_LO_FLD]; // R05
    assign ctl[3] = io_cd_ff[`TCC_IO_HI_FLD]; // R02
    assign cap_mode = {ctl[3][2], ctl[2][2], ctl[1][2], ctl[0][2]}; // R02 R05
    assign active = {~buf_ff[1], ~buf_ff[0], 2'b11}; // R17

    // Pin edges from settled samples
    assign rise = pin_s2_ff & ~pin_s3_ff; // R24
    assign fall = ~pin_s2_ff & pin_s3_ff; // R24

    // Count clock
    always_comb
    begin
        if (cks_ff[`TCC_CKS_EXT])
            tick = start_ff & ext_s2_ff & ~ext_s3_ff;
        else
            tick = start_ff & ((pre_ff & div_mask(cks_ff[1:0])) == div_mask(cks_ff[1:0])); // R08
    end

    // Match fires as the counter leaves the value
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            match[i] = tick & ~cap_mode[i] & active[i] & (cnt_ff == gr_ff[i]); // R13 R22
            cap[i] = cap_mode[i] & active[i] & edge_hit(ctl[i][1:0], rise[i], fall[i]); // R04 R07 R15
        end
    end

    assign ovf_evt = tick & (cnt_ff == `TCC_COUNT_MAX); // R10

    // APB decode
    assign acc = psel & penable;
    assign wr = acc & pready_ff & pwrite;
    assign rd = acc & pready_ff & ~pwrite;

    always_comb
    begin
        rdata = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `TCC_OFS_CTRL: rdata[4:0] = {start_ff, counter_clear_on_match_a_ff, cks_ff};
            `TCC_OFS_MODE: rdata[1:0] = buf_ff;
            `TCC_OFS_IRQEN: rdata[4:0] = {overflow_irq_enable_ff, imie_ff};
            `TCC_OFS_STATUS: rdata[4:0] = {ovf_ff, imf_ff};
            `TCC_OFS_IOAB: rdata[7:0] = io_ab_ff | `TCC_IO_RSVD;
            `TCC_OFS_IOCD: rdata[7:0] = io_cd_ff | `TCC_IO_RSVD; // R01
            `TCC_OFS_COUNT: rdata[15:0] = cnt_ff; // R11
            gr_addr(2'd0): rdata[15:0] = gr_ff[0]; // R19
            gr_addr(2'd1): rdata[15:0] = gr_ff[1];
            gr_addr(2'd2): rdata[15:0] = gr_ff[2];
            gr_addr(2'd3): rdata[15:0] = gr_ff[3];
            default: hit = 1'b0;
        endcase
    end

    // Bus answer, one wait state
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= acc & ~pready_ff;
            pslverr_ff <= acc & ~pready_ff & ~hit;
            if (acc & ~pready_ff & ~pwrite)
                prdata_ff <= rdata;
        end
    end

    // Configuration registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cks_ff <= 3'h0;
            counter_clear_on_match_a_ff <= 1'b0;
            start_ff <= 1'b0;
            buf_ff <= 2'h0;
            overflow_irq_enable_ff <= 1'b0;
            imie_ff <= 4'h0;
            io_ab_ff <= `TCC_IO_RST;
            io_cd_ff <= `TCC_IO_RST;
        end
        else if (wr)
        begin
            case (paddr)
                `TCC_OFS_CTRL:
                begin
                    cks_ff <= pwdata[`TCC_CKS_FLD];
                    counter_clear_on_match_a_ff <= pwdata[`TCC_COUNTER_CLEAR_ON_MATCH_A_BIT];
                    start_ff <= pwdata[`TCC_START_BIT];
                end
                `TCC_OFS_MODE: buf_ff <= {pwdata[`TCC_BUFFER_ENABLE_B_BIT], pwdata[`TCC_BUFFER_ENABLE_A_BIT]};
                `TCC_OFS_IRQEN:
                begin
                    overflow_irq_enable_ff <= pwdata[`TCC_OVF_BIT];
                    imie_ff <= pwdata[`TCC_IMF_FLD];
                end
                `TCC_OFS_IOAB: io_ab_ff <= pwdata[7:0] & ~`TCC_IO_RSVD;
                `TCC_OFS_IOCD: io_cd_ff <= pwdata[7:0] & ~`TCC_IO_RSVD; // R01
                default:
                begin
                end
            endcase
        end
    end

    // Prescaler and input synchronisers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pre_ff <= 3'h0;
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            pin_s3_ff <= 4'h0;
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= pre_ff + 3'h1;
            pin_s1_ff <= timer_pin_in; // R24
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            ext_s1_ff <= ext_count_clk;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    // Counter
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cnt_ff <= `TCC_COUNT_RST; // R12
        else if (wr && paddr == `TCC_OFS_COUNT)
            cnt_ff <= pwdata[15:0]; // R08
        else if (tick)
        begin
            if (match[0] && counter_clear_on_match_a_ff)
                cnt_ff <= `TCC_COUNT_RST; // R09
            else
                cnt_ff <= cnt_ff + 16'h0001; // R08
        end
    end

    // General registers, hardware wins over software
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
                gr_ff[i] <= `TCC_GR_RST; // R20
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr && paddr == gr_addr(2'(i)))
                    gr_ff[i] <= pwdata[15:0];
                if (cap[i])
                    gr_ff[i] <= cnt_ff; // R15
            end
            for (int i = 0; i < 2; i++)
            begin
                if (buf_ff[i] && match[i])
                    gr_ff[i] <= gr_ff[i + 2]; // R18
                if (buf_ff[i] && cap[i])
                    gr_ff[i + 2] <= gr_ff[i]; // R21
            end
        end
    end

    // Flags, set wins over clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            imf_ff <= 4'h0;
            ovf_ff <= 1'b0;
            imf_seen_ff <= 4'h0;
            ovf_seen_ff <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `TCC_OFS_STATUS)
            begin
                imf_ff <= (imf_ff & ~(imf_seen_ff & ~pwdata[`TCC_IMF_FLD])) | match | cap; // R23
                imf_seen_ff <= imf_seen_ff & pwdata[`TCC_IMF_FLD];
                ovf_ff <= (ovf_ff & ~(ovf_seen_ff & ~pwdata[`TCC_OVF_BIT])) | ovf_evt;
                ovf_seen_ff <= ovf_seen_ff & pwdata[`TCC_OVF_BIT];
            end
            else
            begin
                imf_ff <= imf_ff | match | cap; // R13 R15
                ovf_ff <= ovf_ff | ovf_evt; // R10
                if (rd && paddr == `TCC_OFS_STATUS)
                begin
                    imf_seen_ff <= imf_seen_ff | prdata_ff[`TCC_IMF_FLD]; // R23
                    ovf_seen_ff <= ovf_seen_ff | prdata_ff[`TCC_OVF_BIT];
                end
            end
        end
    end

    // Pin drive and interrupt
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            out_ff <= 4'h0;
            oe_n_ff <= 4'hF;
            irq_ff <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (match[i])
                    out_ff[i] <= act_next(ctl[i][1:0], out_ff[i]); // R03 R06
                oe_n_ff[i] <= cap_mode[i] | ~active[i] | (ctl[i][1:0] == TCC_ACT_NONE);
            end
            irq_ff <= |({ovf_ff, imf_ff} & {overflow_irq_enable_ff, imie_ff}); // R10 R14 R16
        end
    end

    assign pready = pready_ff;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;
    assign timer_pin_out = out_ff;
    assign timer_pin_oe_n = oe_n_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_stat_zero_write;
        wr && paddr == `TCC_OFS_STATUS && !pwdata[0] && imf_seen_ff[0];
    endsequence

    sequence s_no_event_a;
        !match[0] && !cap[0];
    endsequence

    a_rsvd_ones: assert property ( // R01
        (acc && !pready_ff && !pwrite && paddr == `TCC_OFS_IOCD) |=> prdata[7] && prdata[3])
        else $error("reserved bits not read as one");

    a_d_capture: assert property ( // R04
        cap[3] |=> gr_ff[3] == $past(cnt_ff) && imf_ff[3])
        else $error("capture D lost count or flag");

    a_c_rise_edge: assert property ( // R07
        (ctl[2] == 3'b100 && active[2] && rise[2]) |=> imf_ff[2] && gr_ff[2] == $past(cnt_ff))
        else $error("rising edge on C not captured");

    a_d_toggle: assert property ( // R03
        (match[3] && ctl[3][1:0] == 2'b11) |=> timer_pin_out[3] != $past(timer_pin_out[3]))
        else $error("pin D did not toggle");

    a_c_low: assert property ( // R06
        (match[2] && ctl[2][1:0] == 2'b01) |=> !timer_pin_out[2])
        else $error("pin C not driven low");

    a_clear_on_a: assert property ( // R09
        (match[0] && counter_clear_on_match_a_ff && !(wr && paddr == `TCC_OFS_COUNT)) |=> cnt_ff == `TCC_COUNT_RST)
        else $error("counter not cleared on match A");

    a_ovf_set: assert property ( // R10
        ovf_evt |=> ovf_ff ##1 (irq || !$past(overflow_irq_enable_ff)))
        else $error("overflow flag or request missing");

    a_flag_clear: assert property ( // R23
        (s_stat_zero_write and s_no_event_a) |=> !imf_ff[0])
        else $error("flag A not cleared after read");

    a_flag_guard: assert property ( // R23
        $fell(imf_ff[0]) |-> $past(imf_seen_ff[0]))
        else $error("flag A cleared without prior read");

    a_buffer_a: assert property ( // R18
        (buf_ff[0] && match[0]) |=> gr_ff[0] == $past(gr_ff[2]))
        else $error("buffer C not copied into A");

    a_irq_match: assert property ( // R14
        (match[1] && imie_ff[1]) |=> imf_ff[1] ##1 (irq || !$past(imie_ff[1])))
        else $error("match B request missing");

endmodule

// ---- test/tcc_pin_model.sv ----
`timescale 1ns/10ps
module tcc_pin_model (
    // Levels from the external source
    input wire logic [3:0] ext_lvl,
    // Device side of the pins
    input wire tcc_pkg::tcc_chan_t pin_out,
    input wire tcc_pkg::tcc_chan_t pin_oe_n,
    output tcc_pkg::tcc_chan_t pin_in
);
    import tcc_pkg::*;

    // Driven pins read back the device level, others the source
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule

// ---- test/tcc_timer_tb.sv ----
`timescale 1ns/10ps
`include "tcc_map.svh"
module tcc_timer_tb;
    import tcc_pkg::*;
    localparam logic [7:0] R_CTL = `TCC_OFS_CTRL;
    localparam logic [7:0] R_MOD = `TCC_OFS_MODE;
    localparam logic [7:0] R_IEN = `TCC_OFS_IRQEN;
    localparam logic [7:0] R_STS = `TCC_OFS_STATUS;
    localparam logic [7:0] R_IAB = `TCC_OFS_IOAB;
    localparam logic [7:0] R_ICD = `TCC_OFS_IOCD;
    localparam logic [7:0] R_CNT = `TCC_OFS_COUNT;
    localparam logic [7:0] R_GA = `TCC_OFS_GRA;
    localparam logic [7:0] R_GB = `TCC_OFS_GRA + 8'h04;
    localparam logic [7:0] R_GC = `TCC_OFS_GRA + 8'h08;
    localparam logic [7:0] R_GD = `TCC_OFS_GRA + 8'h0C;
    localparam tcc_act_t ACTS [4] = '{TCC_ACT_HIGH, TCC_ACT_LOW, TCC_ACT_TOGGLE, TCC_ACT_NONE};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
    tcc_chan_t pin_in;
    tcc_chan_t pin_out;
    tcc_chan_t pin_oe_n;
    logic [3:0] ext_lvl = 4'h0;
    logic ext_clk = 1'b0;
    logic [31:0] rd;
    logic err;
    logic lvl;
    logic hit;
    int n_errors = 0;
    int checks_done = 0;

    always #4 clock = ~clock;

    tcc_timer dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .timer_pin_in(pin_in), .timer_pin_out(pin_out),
        .timer_pin_oe_n(pin_oe_n), .ext_count_clk(ext_clk), .irq(irq));

    tcc_pin_model pins_u (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_in(pin_in));

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One whole-word APB transfer
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask

    // Read arms the set flags, zero write clears them
    task clr;
        apb(1'b0, R_STS, 32'h0000_0000);
        wr(R_STS, 32'h0000_0000);
    endtask

    task idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        chk("watchdog", 32'h0000_0001, 32'h0000_0000);
        tally_and_finish;
    end

    initial
    begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        rchk("count", R_CNT, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
            rchk("general", R_GA + 8'(4 * i), 32'h0000_FFFF);
        rchk("io cd", R_ICD, 32'h0000_0088);
        wr(R_ICD, 32'h0000_0077);
        rchk("io cd", R_ICD, 32'h0000_00FF);
        wr(R_CNT, 32'h0000_ABCD);
        rchk("count", R_CNT, 32'h0000_ABCD);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, 32'(err));
        chk("unmapped data", 32'h0000_0000, rd);
        $display("test reset done");
        wr(R_IEN, 32'h0000_000C);
        lvl = 1'b0;
        foreach (ACTS[k])
        begin
            wr(R_CTL, 32'h0000_0000);
            wr(R_CNT, 32'h0000_0008);
            wr(R_GC, 32'h0000_0008);
            wr(R_GD, 32'h0000_0008);
            wr(R_ICD, {24'h0000_00, 2'b00, ACTS[k], 2'b00, ACTS[k]});
            clr;
            idle(5);
            rchk("flags held", R_STS, 32'h0000_0000);
            wr(R_CTL, 32'h0000_0010);
            idle(20);
            wr(R_CTL, 32'h0000_0000);
            case (ACTS[k])
                TCC_ACT_LOW: lvl = 1'b0;
                TCC_ACT_HIGH: lvl = 1'b1;
                TCC_ACT_TOGGLE: lvl = ~lvl;
                default: lvl = lvl;
            endcase
            chk("pin cd", 32'({lvl, lvl}), 32'(pin_out[3:2]));
            chk("oe cd", (ACTS[k] == TCC_ACT_NONE) ? 3 : 0, 32'(pin_oe_n[3:2]));
            chk("irq match", 32'h0000_0001, 32'(irq));
            wr(R_STS, 32'h0000_0000);
            rchk("flags match", R_STS, 32'h0000_000C);
            wr(R_STS, 32'h0000_0000);
            rchk("flags cleared", R_STS, 32'h0000_0000);
        end
        $display("test compare done");
        wr(R_CNT, 32'h0000_1234);
        for (int e = 0; e < 4; e++)
        begin
            ext_lvl <= 4'h0;
            wr(R_ICD, {24'h0000_00, 2'b01, 2'(e), 2'b01, 2'(e)});
            for (int s = 1; s >= 0; s--)
            begin
                wr(R_GC, 32'h0000_0000);
                wr(R_GD, 32'h0000_0000);
                clr;
                ext_lvl[3:2] <= (s == 1) ? 2'b11 : 2'b00;
                hit = (s == 1) ? (e != 1) : (e != 0);
                idle(8);
                chk("irq capture", 32'(hit), 32'(irq));
                rchk("flags capture", R_STS, hit ? 32'h0000_000C : 0);
                rchk("reg c", R_GC, hit ? 32'h0000_1234 : 0);
                rchk("reg d", R_GD, hit ? 32'h0000_1234 : 0);
            end
        end
        $display("test capture done");
        wr(R_IEN, 32'h0000_0010);
        wr(R_CNT, 32'h0000_FFFE);
        clr;
        wr(R_CTL, 32'h0000_0010);
        idle(10);
        wr(R_CTL, 32'h0000_0000);
        chk("irq overflow", 32'h0000_0001, 32'(irq));
        rchk("flags overflow", R_STS, 32'h0000_0013);
        clr;
        $display("test overflow done");
        wr(R_IEN, 32'h0000_0002);
        wr(R_IAB, 32'h0000_0000);
        wr(R_MOD, 32'h0000_0003);
        wr(R_GA, 32'h0000_000A);
        wr(R_GB, 32'h0000_0005);
        wr(R_GC, 32'h0000_0014);
        wr(R_GD, 32'h0000_001E);
        wr(R_CNT, 32'h0000_0000);
        wr(R_CTL, 32'h0000_0018);
        idle(12);
        wr(R_CTL, 32'h0000_0008);
        chk("irq match b", 32'h0000_0001, 32'(irq));
        rchk("reg a reload", R_GA, 32'h0000_0014);
        rchk("reg b reload", R_GB, 32'h0000_001E);
        apb(1'b0, R_CNT, 32'h0000_0000);
        chk("count cleared", 32'h0000_0001, 32'(rd < 32'h0000_000A));
        wr(R_CTL, 32'h0000_0000);
        wr(R_MOD, 32'h0000_0001);
        wr(R_IAB, 32'h0000_0004);
        wr(R_CNT, 32'h0000_0777);
        wr(R_GA, 32'h0000_1111);
        wr(R_GC, 32'h0000_2222);
        ext_lvl[0] <= 1'b1;
        idle(8);
        rchk("reg a capture", R_GA, 32'h0000_0777);
        rchk("reg c shifted", R_GC, 32'h0000_1111);
        clr;
        rchk("flags all cleared", R_STS, 32'h0000_0000);
        $display("test buffer done");
        wr(R_CNT, 32'h0000_0000);
        wr(R_CTL, 32'h0000_0012);
        idle(40);
        wr(R_CTL, 32'h0000_0000);
        rchk("count div4", R_CNT, 32'h0000_000B);
        wr(R_CNT, 32'h0000_0000);
        wr(R_CTL, 32'h0000_0014);
        repeat (5)
        begin
            ext_clk <= 1'b1;
            idle(4);
            ext_clk <= 1'b0;
            idle(4);
        end
        wr(R_CTL, 32'h0000_0000);
        rchk("count ext", R_CNT, 32'h0000_0005);
        $display("test clock done");
        tally_and_finish;
    end
endmodule
